/* src/fault_monitor_defs.vh */
// Constants for the dual channel tracking converter and its fault monitor.
`ifndef FAULT_MONITOR_DEFS_VH
`define FAULT_MONITOR_DEFS_VH

// ****************************************************************
// Word layout
// ****************************************************************
`define POS_WIDTH          14
`define POS_MSB            13
`define POS_RESET          14'h0000
`define CHAN_COUNT         2
`define CHAN_FIRST         0
`define CHAN_SECOND        1
`define WORD_BUS_WIDTH     28

// ****************************************************************
// Fault thresholds in counts of the least significant bit
// ****************************************************************
`define ERR_SET_LSB        14'h0037
`define ERR_CLEAR_LSB      14'h002D

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_FREQ_HZ        20000000
`define MAX_RATE_RPS       20
`define COUNTS_PER_REV     16384
`define STEP_CYCLES        (`CLK_FREQ_HZ / (`MAX_RATE_RPS * `COUNTS_PER_REV))
`define STEP_CNT_WIDTH     6
`define SELECT_TIME_NS     50
`define CLK_PERIOD_NS      50
`define SELECT_CYCLES      ((`SELECT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_EDGES_TO_SET   2'h2
`define PERS_RESET         2'h0

// ****************************************************************
// Reset values of the flags
// ****************************************************************
`define FAULT_RESET        1'b1
`define FAULT_N_RESET      1'b0

`endif

/* src/dual_channel_tracking_fault_monitor.v */
// Dual channel tracking counters with a hysteretic, persistent fault monitor.
`timescale 1ns/10ps
`default_nettype none
`include "fault_monitor_defs.vh"

module dual_channel_tracking_fault_monitor (
    // Clock and reset.
    input  wire                        clock_i,
    input  wire                        rst_n_i,
    // Shaft angle per channel, first channel in the low bits.
    input  wire [`WORD_BUS_WIDTH-1:0]  shaft_angle_i,
    // Reference comparator levels per channel.
    input  wire [`CHAN_COUNT-1:0]      reference_high_input_i,
    input  wire [`CHAN_COUNT-1:0]      reference_low_input_i,
    // Signal presence per channel and shared supply health.
    input  wire [`CHAN_COUNT-1:0]      signal_present_i,
    input  wire                        supply_good_i,
    // Channel select from the host.
    input  wire                        channel_select_i,
    // Selected channel outputs.
    output reg  [`POS_WIDTH-1:0]       position_word_o,
    output reg                         fault_n_o
);

    // ****************************************************************
    // Shared synchronisers
    // ****************************************************************

    reg                        sel_s1_reg;
    reg                        sel_s2_reg;
    reg                        supply_s1_reg;
    reg                        supply_s2_reg;

    // Per channel results gathered for the output selector.
    wire [`CHAN_COUNT-1:0]     ch_fault;
    wire [`WORD_BUS_WIDTH-1:0] ch_word;

    // Reload value of the step divider; it is cut to the divider's width where used.
    localparam [31:0] STEP_RELOAD = `STEP_CYCLES - 1;

    // The select pin comes from the host's domain, so it passes two flip-flops.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_s1_reg <= 1'b0;
            sel_s2_reg <= 1'b0;
        end else begin
            sel_s1_reg <= channel_select_i;
            sel_s2_reg <= sel_s1_reg;
        end
    end

    // The supply monitor starts as bad, so both channels leave reset in fault
    // until the synchroniser has seen a good supply for two clocks.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_s1_reg <= 1'b0;
            supply_s2_reg <= 1'b0;
        end else begin
            supply_s1_reg <= supply_good_i;
            supply_s2_reg <= supply_s1_reg;
        end
    end

    // ****************************************************************
    // Per channel tracking loop and monitor
    // ****************************************************************

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_COUNT; ch = ch + 1) begin : g_chan

            reg  [`POS_WIDTH-1:0]     angle_s1_reg;
            reg  [`POS_WIDTH-1:0]     angle_s2_reg;
            reg  [`POS_WIDTH-1:0]     count_reg;
            reg  [`POS_WIDTH-1:0]     count_next;
            reg  [`STEP_CNT_WIDTH-1:0] step_cnt_reg;
            reg  [`STEP_CNT_WIDTH-1:0] step_cnt_next;
            reg                       ref_hi_s1_reg;
            reg                       ref_hi_s2_reg;
            reg                       ref_lo_s1_reg;
            reg                       ref_lo_s2_reg;
            reg                       ref_prev_reg;
            reg                       sig_s1_reg;
            reg                       sig_s2_reg;
            reg  [1:0]                pers_reg;
            reg  [1:0]                pers_next;
            reg                       fault_reg;
            reg                       fault_next;

            wire [`POS_WIDTH-1:0]     err_raw;
            wire [`POS_WIDTH-1:0]     err_mag;
            wire                      err_neg;
            wire                      over_set;
            wire                      under_clear;
            wire                      ref_sign;
            wire                      ref_rise;
            wire                      forced;
            wire                      step_tick;

            // The angle word is sampled bit by bit; a skewed sample costs at most
            // a single wrong step, which the loop then walks back.
            // An angle held for three clocks always gives a clean sample.
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    angle_s1_reg <= `POS_RESET;
                    angle_s2_reg <= `POS_RESET;
                end else begin
                    angle_s1_reg <= shaft_angle_i[ch*`POS_WIDTH +: `POS_WIDTH];
                    angle_s2_reg <= angle_s1_reg;
                end
            end

            // Both reference levels are synchronised before any logic reads them;
            // the edge detector starts low like an idle reference, so no false edge.
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ref_hi_s1_reg <= 1'b0;
                    ref_hi_s2_reg <= 1'b0;
                    ref_lo_s1_reg <= 1'b0;
                    ref_lo_s2_reg <= 1'b0;
                    ref_prev_reg  <= 1'b0;
                end else begin
                    ref_hi_s1_reg <= reference_high_input_i[ch];
                    ref_hi_s2_reg <= ref_hi_s1_reg;
                    ref_lo_s1_reg <= reference_low_input_i[ch];
                    ref_lo_s2_reg <= ref_lo_s1_reg;
                    ref_prev_reg  <= ref_sign;
                end
            end

            // Signal presence starts as lost, so a channel leaves reset in fault.
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sig_s1_reg <= 1'b0;
                    sig_s2_reg <= 1'b0;
                end else begin
                    sig_s1_reg <= signal_present_i[ch];
                    sig_s2_reg <= sig_s1_reg;
                end
            end

            // signed error magnitude.
            // The difference wraps modulo one turn, so the shorter way round wins.
            assign err_raw     = angle_s2_reg - count_reg;
            assign err_neg     = err_raw[`POS_MSB];
            assign err_mag     = err_neg ? (~err_raw + 14'h0001) : err_raw;

            assign over_set    = (err_mag > `ERR_SET_LSB);
            assign under_clear = (err_mag < `ERR_CLEAR_LSB);

            // A reference period is counted between rising edges of its sign,
            // formed only from the synchronised high and low levels.
            assign ref_sign    = ref_hi_s2_reg & ~ref_lo_s2_reg;
            assign ref_rise    = ref_sign & ~ref_prev_reg;

            // lost signal forces this channel's fault.
            // a bad supply prevents tracking and forces the fault.
            assign forced      = ~sig_s2_reg | ~supply_s2_reg;

            // rate limited step.
            // The counter may step once per step period only, so an input faster
            // than the tracking rate builds error until the fault sets.
            assign step_tick   = (step_cnt_reg == {`STEP_CNT_WIDTH{1'b0}});

            always @* begin
                step_cnt_next = step_cnt_reg - 6'h01;
                if (step_tick) begin
                    step_cnt_next = STEP_RELOAD[`STEP_CNT_WIDTH-1:0];
                end
            end

            // one count per step toward the angle.
            // No convert command; the counter simply chases the input.
            always @* begin
                count_next = count_reg;
                if (step_tick && supply_s2_reg && (err_raw != `POS_RESET)) begin
                    if (err_neg) begin
                        count_next = count_reg - 14'h0001;
                    end else begin
                        count_next = count_reg + 14'h0001;
                    end
                end
            end

            // persistence over one reference period.
            // Two rising edges seen while the error stays high span a full period.
            // Any dip to or below the set threshold restarts the wait.
            always @* begin
                pers_next = pers_reg;
                if (!over_set) begin
                    pers_next = `PERS_RESET;
                end else if (ref_rise && (pers_reg != `REF_EDGES_TO_SET)) begin
                    pers_next = pers_reg + 2'h1;
                end
            end

            // each channel keeps its own fault state.
            // a large step sets the fault until the counter resettles.
            // Setting has priority over clearing, and forcing over both.
            always @* begin
                fault_next = fault_reg;
                if (forced) begin
                    fault_next = 1'b1;
                end else if (over_set && (pers_reg == `REF_EDGES_TO_SET)) begin
                    fault_next = 1'b1;
                end else if (under_clear) begin
                    fault_next = 1'b0;
                end
            end

            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    count_reg <= `POS_RESET;
                end else begin
                    count_reg <= count_next;
                end
            end

            // The divider starts at zero, so the first step may fall at once;
            // after that the counter moves no faster than the tracking rate.
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    step_cnt_reg <= {`STEP_CNT_WIDTH{1'b0}};
                end else begin
                    step_cnt_reg <= step_cnt_next;
                end
            end

            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pers_reg <= `PERS_RESET;
                end else begin
                    pers_reg <= pers_next;
                end
            end

            // fault from reset.
            // Starting in fault means the flag stays low until the counter is
            // within the clear threshold, about one degree, of the angle.
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    fault_reg <= `FAULT_RESET;
                end else begin
                    fault_reg <= fault_next;
                end
            end

            assign ch_fault[ch] = fault_reg;
            assign ch_word[ch*`POS_WIDTH +: `POS_WIDTH] = count_reg;
        end
    endgenerate

    // ****************************************************************
    // Output selector
    // ****************************************************************

    // select high means the first channel.
    // selected fault drives the active-low flag.
    // The select pin's synchroniser adds two clocks; that is the price of a
    // glitch-free flag when the host switches channels asynchronously.
    // Next values of the two outputs.
    reg  [`POS_WIDTH-1:0]      position_word_next;
    reg                        fault_n_next;

    // The synchronised select picks the channel.
    always @* begin
        if (sel_s2_reg) begin
            position_word_next = ch_word[`CHAN_FIRST*`POS_WIDTH +: `POS_WIDTH];
            fault_n_next       = ~ch_fault[`CHAN_FIRST];
        end else begin
            position_word_next = ch_word[`CHAN_SECOND*`POS_WIDTH +: `POS_WIDTH];
            fault_n_next       = ~ch_fault[`CHAN_SECOND];
        end
    end

    // Both outputs leave a flip-flop, so the host never sees the mux settle.
    // A channel switch therefore costs one clock more than the mux alone.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            position_word_o <= `POS_RESET;
            fault_n_o       <= `FAULT_N_RESET;
        end else begin
            position_word_o <= position_word_next;
            fault_n_o       <= fault_n_next;
        end
    end

endmodule
`default_nettype wire

/* test/fault_monitor_checker.sv */
// Port-level checker for the tracking fault monitor.
`timescale 1ns/10ps
`default_nettype none
`include "fault_monitor_defs.vh"
module fault_monitor_checker (
    // Clock, reset and inputs.
    input wire logic                       clock_i,
    input wire logic                       rst_n_i,
    input wire logic [`WORD_BUS_WIDTH-1:0] shaft_angle_i,
    input wire logic [`CHAN_COUNT-1:0]     reference_high_input_i,
    input wire logic [`CHAN_COUNT-1:0]     reference_low_input_i,
    input wire logic [`CHAN_COUNT-1:0]     signal_present_i,
    input wire logic                       supply_good_i,
    input wire logic                       channel_select_i,
    // Outputs watched.
    input wire logic [`POS_WIDTH-1:0]      position_word_o,
    input wire logic                       fault_n_o
);
    // ****************************************************************
    // Helper ages
    // ****************************************************************
    logic [3:0] sel_age_reg;
    logic [5:0] quiet_reg;
    logic       sel_old_reg;
    logic [1:0] ref_old_reg;
    wire  [1:0] ref_pos = reference_high_input_i & ~reference_low_input_i;
    wire        sel_sig = channel_select_i ? signal_present_i[0] : signal_present_i[1];
    wire        unrest  = (ref_pos != ref_old_reg) | ~supply_good_i | ~&signal_present_i;
    // Saturating ages; a new fault is impossible while the references stay quiet, the supply stays good and both signals stay present.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_age_reg <= 4'h0;
            quiet_reg   <= 6'h00;
            sel_old_reg <= 1'b0;
            ref_old_reg <= 2'h0;
        end else begin
            sel_old_reg <= channel_select_i;
            ref_old_reg <= ref_pos;
            sel_age_reg <= (channel_select_i != sel_old_reg) ? 4'h0 : sel_age_reg + {3'h0, ~&sel_age_reg};
            quiet_reg   <= unrest ? 6'h00 : quiet_reg + {5'h00, ~&quiet_reg};
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    reset_values_a: assert property (disable iff (1'b0)
        !rst_n_i ##1 !rst_n_i |-> !fault_n_o && position_word_o == 14'h0000)
        else $error("reset outputs wrong");
    powerup_fault_a: assert property (
        $rose(rst_n_i) |-> !fault_n_o ##1 !fault_n_o) else $error("fault cleared too early");
    pos_step_a: assert property (sel_age_reg == 4'hF |->
        (position_word_o - $past(position_word_o)) inside {14'h0000, 14'h0001, 14'h3FFF})
        else $error("position jumped");
    rate_limit_a: assert property (sel_age_reg == 4'hF && $changed(position_word_o) |=>
        ($stable(position_word_o) || sel_age_reg != 4'hF)[*8]) else $error("step too fast");
    supply_freeze_a: assert property (
        (!supply_good_i && sel_age_reg == 4'hF)[*5] |-> $stable(position_word_o))
        else $error("counter moved without supply");
    supply_fault_a: assert property (
        (!supply_good_i)[*5] |-> !fault_n_o) else $error("no fault without supply");
    signal_fault_a: assert property (
        (!sel_sig && sel_age_reg == 4'hF)[*5] |-> !fault_n_o) else $error("no fault on lost signal");
    persist_check_a: assert property (
        sel_age_reg == 4'hF && quiet_reg >= 6'h0A |-> !$fell(fault_n_o)) else $error("fault too soon");
    clear_cause_a: assert property (
        $rose(fault_n_o) && sel_age_reg == 4'hF |-> $past(supply_good_i, 4) && $past(sel_sig, 4))
        else $error("fault cleared while forced");
    cover property ($fell(fault_n_o));
    cover property ($rose(fault_n_o) && sel_age_reg == 4'hF);
    cover property ((!supply_good_i)[*5]);
endmodule
`default_nettype wire

/* test/tracking_host_model.sv */
// Host model that drives the channel select for reads.
`timescale 1ns/10ps
`default_nettype none
module tracking_host_model (
    input  wire logic clock_i,
    input  wire logic sel_req_i,
    output wire logic channel_select_o
);
    // select polarity
    // High reads the first channel, low the second; changes land just after an edge.
    logic sel_reg = 1'b1;
    always @(posedge clock_i) sel_reg <= #1 sel_req_i;
    assign channel_select_o = sel_reg;
endmodule
`default_nettype wire

/* test/test_dual_channel_tracking_fault_monitor.sv */
// Self-checking bench for the tracking fault monitor.
`timescale 1ns/10ps
`default_nettype none
`include "fault_monitor_defs.vh"
module test_dual_channel_tracking_fault_monitor;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [27:0] angle = 28'h000_0000;
    logic [1:0]  ref_hi = 2'h0;
    logic [1:0]  sig_ok = 2'h3;
    logic        supply = 1'b1;
    logic        sel_req = 1'b1;
    wire         sel;
    wire  [13:0] pos;
    wire         fault_n;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    // Reference of 40 clocks per period, plus a guard against hangs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles % 20 == 19) ref_hi <= #1 ~ref_hi;
        if (cycles == 30000) begin
            err_total++;
            finish_test;
        end
    end
    dual_channel_tracking_fault_monitor u_dut (.clock_i(clk), .rst_n_i(rst_n),
        .shaft_angle_i(angle), .reference_high_input_i(ref_hi),
        .reference_low_input_i(~ref_hi), .signal_present_i(sig_ok), .supply_good_i(supply),
        .channel_select_i(sel), .position_word_o(pos), .fault_n_o(fault_n));
    tracking_host_model u_host (.clock_i(clk), .sel_req_i(sel_req), .channel_select_o(sel));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_fault(input logic lvl, input int limit);
        for (int i = 0; i < limit && fault_n !== lvl; i++) step(1);
    endtask
    task finish_test;
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_step;
        angle[13:0] = 14'h0064;
        step(6);
        check(fault_n, 1'b1);
        wait_fault(1'b0, 150);
        check(fault_n, 1'b0);
        sel_req = 1'b0;
        step(6);
        check(fault_n, 1'b1);
        check(pos, 14'h0000);
        sel_req = 1'b1;
        step(6);
        check(fault_n, 1'b0);
        wait_fault(1'b1, 5000);
        check(pos, 14'h0038);
        for (int i = 0; i < 3000 && pos !== 14'h0064; i++) step(1);
        check(pos, 14'h0064);
    endtask
    task t_faults;
        sig_ok = 2'h1;
        step(6);
        check(fault_n, 1'b1);
        sig_ok = 2'h2;
        step(6);
        check(fault_n, 1'b0);
        sig_ok = 2'h3;
        wait_fault(1'b1, 20);
        supply = 1'b0;
        angle[13:0] = 14'h00C8;
        step(150);
        check(pos, 14'h0064);
        check(fault_n, 1'b0);
        supply = 1'b1;
        angle[13:0] = 14'h0064;
        wait_fault(1'b1, 20);
        check(fault_n, 1'b1);
    endtask
    task t_band;
        angle[13:0] = 14'h009B;
        step(200);
        check(fault_n, 1'b1);
        for (int i = 0; i < 150; i++) begin
            angle[13:0] = angle[13:0] + 14'h0001;
            step(20);
        end
        check(fault_n, 1'b0);
    endtask
    initial begin
        step(20);
        rst_n = 1'b1;
        step(20);
        check(fault_n, 1'b1);
        t_step;
        t_faults;
        t_band;
        finish_test;
    end
endmodule
bind dual_channel_tracking_fault_monitor fault_monitor_checker u_chk (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .shaft_angle_i(shaft_angle_i),
    .reference_high_input_i(reference_high_input_i),
    .reference_low_input_i(reference_low_input_i), .signal_present_i(signal_present_i),
    .supply_good_i(supply_good_i), .channel_select_i(channel_select_i),
    .position_word_o(position_word_o), .fault_n_o(fault_n_o));
`default_nettype wire
